// file: rtl/rbst_top.sv
// Scan test controls and the two memory self-test ports of the cluster
`timescale 1ns/1ps
`default_nettype none
module rbst_top #(
  parameter bit ECC_EN      = 1'b0,
  parameter int L1_ARRAYS   = rbst_pkg::L1_ARRAYS,
  parameter int IRAM_ARRAYS = rbst_pkg::IRAM_ARRAYS,
  parameter int L1_DW       = rbst_pkg::l1_dw(ECC_EN),
  parameter int IRAM_DW     = rbst_pkg::iram_dw(ECC_EN)
) (
  input  wire logic                            ref_clk,
  input  wire logic                            rst_n,
  input  wire logic                            clk_en,
  input  wire logic                            scan_shift_en,
  input  wire logic                            ram_hold_during_shift,
  input  wire logic                            ram_clock_force,
  input  wire logic                            test_bypass_mode,
  input  wire logic [rbst_pkg::REQ_W-1:0]      wait_for_interrupt_state,
  output logic                                 ram_clk_on,
  output logic [rbst_pkg::REQ_W-1:0]           l1_test_ack,
  input  wire logic [rbst_pkg::REQ_W-1:0]      l1_test_req,
  input  wire logic [rbst_pkg::CFG_W-1:0]      l1_test_cfg,
  input  wire logic [rbst_pkg::L1_AW-1:0]      l1_test_addr,
  input  wire logic [L1_DW-1:0]                l1_test_wdata,
  output logic [L1_DW-1:0]                     l1_test_rdata,
  input  wire logic                            l1_test_wr_en,
  input  wire logic                            l1_test_rd_en,
  input  wire logic [rbst_pkg::L1_ARR_W-1:0]   l1_test_array_sel,
  input  wire logic [L1_DW-1:0]                l1_test_bit_mask,
  output logic [rbst_pkg::REQ_W-1:0]           iram_test_ack,
  input  wire logic [rbst_pkg::REQ_W-1:0]      iram_test_req,
  input  wire logic [rbst_pkg::CFG_W-1:0]      iram_test_cfg,
  input  wire logic [rbst_pkg::IRAM_AW-1:0]    iram_test_addr,
  input  wire logic [IRAM_DW-1:0]              iram_test_wdata,
  output logic [IRAM_DW-1:0]                   iram_test_rdata,
  input  wire logic                            iram_test_wr_en,
  input  wire logic                            iram_test_rd_en,
  input  wire logic [rbst_pkg::IRAM_ARR_W-1:0] iram_test_array_sel,
  input  wire logic                            iram_test_bit_wr_en
);
  localparam int L1_AR_W = rbst_pkg::L1_ARR_W;
  localparam int IR_AR_W = rbst_pkg::IRAM_ARR_W;

  logic [rbst_pkg::REQ_W-1:0] l1_mode_reg;
  logic [rbst_pkg::REQ_W-1:0] l1_mode_next;
  logic [rbst_pkg::REQ_W-1:0] iram_mode_reg;
  logic [rbst_pkg::REQ_W-1:0] iram_mode_next;
  rbst_pkg::rbst_port_t       l1_state;
  rbst_pkg::rbst_port_t       iram_state;

  function automatic rbst_pkg::rbst_port_t port_state(
    input logic [rbst_pkg::REQ_W-1:0] mode
  );
    case (mode)
      '0:       return rbst_pkg::RBST_PORT_OFF;
      '1:       return rbst_pkg::RBST_PORT_FULL;
      default:  return rbst_pkg::RBST_PORT_PART;
    endcase
  endfunction

  // Request is sampled so that ack is a clean flop output
  assign l1_mode_next   = l1_test_req;
  assign iram_mode_next = iram_test_req;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      l1_mode_reg   <= '0;
      iram_mode_reg <= '0;
    end else if (clk_en) begin
      l1_mode_reg   <= l1_mode_next;
      iram_mode_reg <= iram_mode_next;
    end
  end

  assign l1_test_ack   = ~l1_mode_reg;
  assign iram_test_ack = ~iram_mode_reg;
  assign l1_state      = port_state(l1_mode_reg);
  assign iram_state    = port_state(iram_mode_reg);

  wire l1_active   = (l1_state != rbst_pkg::RBST_PORT_OFF);
  wire iram_active = (iram_state != rbst_pkg::RBST_PORT_OFF);

  // RAM clock gate: stops when every processor waits, unless forced or in test bypass mode
  wire all_wait = &wait_for_interrupt_state;
  assign ram_clk_on = test_bypass_mode
                    | ram_clock_force
                    | ~all_wait;

  // Scan shift with hold freezes RAM contents; reads stay harmless
  wire ram_hold = scan_shift_en & ram_hold_during_shift;

  wire l1_arr_ok = (l1_test_array_sel < L1_AR_W'(L1_ARRAYS));
  wire ir_arr_ok = (iram_test_array_sel < IR_AR_W'(IRAM_ARRAYS));
  wire iram_all  = iram_test_cfg[rbst_pkg::CFG_ALL_BIT];

  // One gate for both ports keeps hold and clock rules identical on each
  function automatic logic access_ok(
    input logic active,
    input logic strobe,
    input logic clk_ok,
    input logic blocked
  );
    return active & strobe & clk_ok & ~blocked;
  endfunction

  wire l1_we = access_ok(l1_active, l1_test_wr_en, ram_clk_on, ram_hold);
  wire l1_re = access_ok(l1_active, l1_test_rd_en, ram_clk_on, 1'b0);
  wire ir_we = access_ok(iram_active, iram_test_wr_en, ram_clk_on, ram_hold);
  wire ir_re = access_ok(iram_active, iram_test_rd_en, ram_clk_on, 1'b0);

  // Single bit-write enable applies to the whole instruction RAM word
  wire [IRAM_DW-1:0] ir_mask = {IRAM_DW{iram_test_bit_wr_en}};

  // Level-one arrays and the data tight RAM share this bank
  rbst_ram #(
    .DW     (L1_DW),
    .AW     (rbst_pkg::L1_AW),
    .ARR_W  (L1_AR_W),
    .ARRAYS (L1_ARRAYS)
  ) u_l1_ram (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .we         (l1_we),
    .re         (l1_re),
    .all_arrays (1'b0),
    .arr_ok     (l1_arr_ok),
    .arr        (l1_test_array_sel),
    .addr       (l1_test_addr),
    .wdata      (l1_test_wdata),
    .wmask      (l1_test_bit_mask),
    .rdata      (l1_test_rdata)
  );

  rbst_ram #(
    .DW     (IRAM_DW),
    .AW     (rbst_pkg::IRAM_AW),
    .ARR_W  (IR_AR_W),
    .ARRAYS (IRAM_ARRAYS)
  ) u_iram (
    .ref_clk    (ref_clk),
    .rst_n      (rst_n),
    .clk_en     (clk_en),
    .we         (ir_we),
    .re         (ir_re),
    .all_arrays (iram_all),
    .arr_ok     (ir_arr_ok),
    .arr        (iram_test_array_sel),
    .addr       (iram_test_addr),
    .wdata      (iram_test_wdata),
    .wmask      (ir_mask),
    .rdata      (iram_test_rdata)
  );

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  a_l1_data_width: assert property (
    L1_DW == (ECC_EN ? 78 : 64))
    else $error("level-one data width does not follow ECC build");

  a_iram_data_width: assert property (
    IRAM_DW == (ECC_EN ? 72 : 64))
    else $error("instruction RAM data width does not follow ECC build");

  a_l1_ack_follow: assert property (
    clk_en |=> l1_test_ack == ~$past(l1_test_req))
    else $error("level-one ack does not mirror request");

  a_iram_ack_follow: assert property (
    clk_en |=> iram_test_ack == ~$past(iram_test_req))
    else $error("instruction RAM ack does not mirror request");

  a_hold_no_write: assert property (
    (scan_shift_en && ram_hold_during_shift) |-> !l1_we && !ir_we)
    else $error("RAM written while held during shift");

  a_force_ram_clock: assert property (
    (ram_clock_force || !all_wait) |-> ram_clk_on)
    else $error("RAM clock stopped while forced or processors run");

  a_wait_gates_clock: assert property (
    (all_wait && !ram_clock_force && !test_bypass_mode) |-> !ram_clk_on)
    else $error("RAM clock gate not applied in full wait");

  a_bypass_gate: assert property (
    test_bypass_mode |-> ram_clk_on)
    else $error("bypass mode did not bypass RAM clock gate");

  a_idle_no_access: assert property (
    (l1_test_ack == rbst_pkg::ACK_IDLE) |-> !l1_we && !l1_re)
    else $error("level-one RAM accessed outside test mode");

  a_bad_array_zero: assert property (
    (clk_en && l1_re && !l1_arr_ok) |=> l1_test_rdata == '0)
    else $error("unbuilt array did not read as zero");

  sequence s_l1_full_write;
    clk_en && l1_we && l1_arr_ok && (&l1_test_bit_mask);
  endsequence

  a_l1_write_read: assert property (
    s_l1_full_write ##1
      (clk_en && l1_re && !l1_we
       && l1_test_addr == $past(l1_test_addr)
       && l1_test_array_sel == $past(l1_test_array_sel))
    |=> l1_test_rdata == $past(l1_test_wdata, 2))
    else $error("level-one read did not return written word");

  sequence s_ir_write;
    clk_en && ir_we && ir_arr_ok && iram_test_bit_wr_en;
  endsequence

  a_iram_write_read: assert property (
    s_ir_write ##1
      (clk_en && ir_re && !ir_we
       && iram_test_addr == $past(iram_test_addr)
       && iram_test_array_sel == $past(iram_test_array_sel))
    |=> iram_test_rdata == $past(iram_test_wdata, 2))
    else $error("instruction RAM read did not return written word");

  c_l1_write_read: cover property (s_l1_full_write ##1 (clk_en && l1_re));
  c_iram_all_write: cover property (clk_en && ir_we && iram_all);
  c_hold_blocked: cover property (ram_hold && l1_active && l1_test_wr_en);
  c_forced_in_wait: cover property (all_wait && ram_clock_force && l1_re);
  c_clk_frozen: cover property (!clk_en && l1_test_wr_en && l1_active);

  a_freeze_l1_ack: assert property (
    !clk_en |=> $stable(l1_test_ack))
    else $error("level-one ack moved while clock enable low");

  a_freeze_ir_ack: assert property (
    !clk_en |=> $stable(iram_test_ack))
    else $error("instruction RAM ack moved while clock enable low");

  a_freeze_l1_data: assert property (
    !clk_en |=> $stable(l1_test_rdata))
    else $error("level-one read data moved while clock enable low");

  a_freeze_ir_data: assert property (
    !clk_en |=> $stable(iram_test_rdata))
    else $error("instruction RAM read data moved while clock enable low");

  a_l1_rdata_hold: assert property (
    !l1_re |=> $stable(l1_test_rdata))
    else $error("level-one read data changed without a read");

  a_ir_rdata_hold: assert property (
    !ir_re |=> $stable(iram_test_rdata))
    else $error("instruction RAM read data changed without a read");

  a_iram_idle_access: assert property (
    (iram_test_ack == rbst_pkg::ACK_IDLE) |-> !ir_we && !ir_re)
    else $error("instruction RAM accessed outside test mode");

  a_gated_no_access: assert property (
    !ram_clk_on |-> !l1_we && !l1_re && !ir_we && !ir_re)
    else $error("RAM accessed while its clock is gated");

  a_hold_reads_pass: assert property (
    (ram_hold && l1_active && l1_test_rd_en && ram_clk_on) |-> l1_re)
    else $error("read refused during RAM hold");

  a_ir_bad_zero: assert property (
    (clk_en && ir_re && !ir_arr_ok) |=> iram_test_rdata == '0)
    else $error("unbuilt instruction array did not read as zero");

  a_l1_active_ack: assert property (
    l1_active == (l1_test_ack != rbst_pkg::ACK_IDLE))
    else $error("level-one port activity disagrees with ack");

  a_ir_active_ack: assert property (
    iram_active == (iram_test_ack != rbst_pkg::ACK_IDLE))
    else $error("instruction RAM port activity disagrees with ack");

  a_l1_full_mode: assert property (
    (l1_test_ack == '0) |-> l1_state == rbst_pkg::RBST_PORT_FULL)
    else $error("both processors requested but port not in full mode");

  a_l1_write_gate: assert property (
    (l1_active && l1_test_wr_en && ram_clk_on && !ram_hold) |-> l1_we)
    else $error("legal level-one write was not passed to the RAM");

  a_ir_write_gate: assert property (
    (iram_active && iram_test_wr_en && ram_clk_on && !ram_hold) |-> ir_we)
    else $error("legal instruction RAM write was not passed to the RAM");
endmodule
`default_nettype wire

// file: rtl/rbst_pkg.sv
// Shared widths and constants for the RAM self-test and scan test port
package rbst_pkg;
  localparam int REQ_W         = 2;
  localparam int CFG_W         = 2;
  localparam int CFG_ALL_BIT   = 0;
  localparam int L1_AW         = 14;
  localparam int L1_ARR_W      = 6;
  localparam int L1_DW_PLAIN   = 64;
  localparam int L1_DW_ECC     = 78;
  localparam int IRAM_AW       = 12;
  localparam int IRAM_ARR_W    = 5;
  localparam int IRAM_DW_PLAIN = 64;
  localparam int IRAM_DW_ECC   = 72;
  localparam int L1_ARRAYS     = 4;
  localparam int IRAM_ARRAYS   = 2;
  localparam logic [REQ_W-1:0] ACK_IDLE = 2'h3;

  typedef enum logic [1:0] {
    RBST_PORT_OFF   = 2'h0,
    RBST_PORT_PART  = 2'h1,
    RBST_PORT_FULL  = 2'h3
  } rbst_port_t;

  function automatic int l1_dw(input bit ecc);
    return ecc ? L1_DW_ECC : L1_DW_PLAIN;
  endfunction

  function automatic int iram_dw(input bit ecc);
    return ecc ? IRAM_DW_ECC : IRAM_DW_PLAIN;
  endfunction
endpackage

// file: rtl/rbst_ram.sv
// Test-reachable RAM bank: several arrays, bit-masked writes, registered read
`timescale 1ns/1ps
`default_nettype none
module rbst_ram #(
  parameter int DW     = 64,
  parameter int AW     = 14,
  parameter int ARR_W  = 6,
  parameter int ARRAYS = 4
) (
  input  wire logic             ref_clk,
  input  wire logic             rst_n,
  input  wire logic             clk_en,
  input  wire logic             we,
  input  wire logic             re,
  input  wire logic             all_arrays,
  input  wire logic             arr_ok,
  input  wire logic [ARR_W-1:0] arr,
  input  wire logic [AW-1:0]    addr,
  input  wire logic [DW-1:0]    wdata,
  input  wire logic [DW-1:0]    wmask,
  output logic      [DW-1:0]    rdata
);
  localparam int LW = $clog2(ARRAYS);

  logic [DW-1:0] mem [ARRAYS << AW];
  logic [DW-1:0] rdata_reg;
  wire  [LW-1:0] arr_lo = arr[LW-1:0];
  wire  [LW+AW-1:0] rd_idx = {arr_lo, addr};

  function automatic logic [DW-1:0] merge(
    input logic [DW-1:0] old_w,
    input logic [DW-1:0] new_w,
    input logic [DW-1:0] mask
  );
    return (old_w & ~mask) | (new_w & mask);
  endfunction

  // All-arrays mode writes every array at once to speed up march patterns
  always_ff @(posedge ref_clk) begin
    if (clk_en && we) begin
      for (int a = 0; a < ARRAYS; a++) begin
        if (all_arrays || (arr_ok && arr_lo == LW'(a))) begin
          mem[{LW'(a), addr}] <= merge(mem[{LW'(a), addr}], wdata, wmask);
        end
      end
    end
  end

  // Unbuilt arrays read as zero rather than aliasing a real one
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdata_reg <= '0;
    end else if (clk_en && re) begin
      rdata_reg <= arr_ok ? mem[rd_idx] : '0;
    end
  end

  assign rdata = rdata_reg;
endmodule
`default_nettype wire

// file: tb/rbst_bist_model.sv
// Behavioural memory self-test controller driving both test ports
`timescale 1ns/1ps
`default_nettype none
module rbst_bist_model (
  input  wire logic   ref_clk,
  output logic [1:0]  l1_req,
  output logic [1:0]  l1_cfg,
  output logic [13:0] l1_addr,
  output logic [63:0] l1_wdata,
  output logic        l1_wr_en,
  output logic        l1_rd_en,
  output logic [5:0]  l1_sel,
  output logic [63:0] l1_mask,
  output logic [1:0]  ir_req,
  output logic [1:0]  ir_cfg,
  output logic [11:0] ir_addr,
  output logic [63:0] ir_wdata,
  output logic        ir_wr_en,
  output logic        ir_rd_en,
  output logic [4:0]  ir_sel,
  output logic        ir_bit_wr_en
);
  initial begin
    {l1_req, l1_cfg, l1_addr, l1_wdata, l1_wr_en, l1_rd_en, l1_sel, l1_mask} = '0;
    {ir_req, ir_cfg, ir_addr, ir_wdata, ir_wr_en, ir_rd_en, ir_sel, ir_bit_wr_en} = '0;
  end
  task automatic set_req(input bit p, input logic [1:0] r);
    @(posedge ref_clk);
    if (p) ir_req <= r;
    else l1_req <= r;
  endtask
  // One-cycle access; strobes drop after the sampling edge, data lines flip when released
  task automatic acc(input bit p, input bit w, input logic [5:0] s, input logic [13:0] a,
                     input logic [63:0] d, input logic [63:0] m, input logic c);
    @(posedge ref_clk);
    if (p) begin
      ir_wr_en <= w; ir_rd_en <= !w; ir_sel <= s[4:0]; ir_addr <= a[11:0];
      ir_wdata <= d; ir_bit_wr_en <= m[0]; ir_cfg <= {1'b0, c};
    end else begin
      l1_wr_en <= w; l1_rd_en <= !w; l1_sel <= s; l1_addr <= a;
      l1_wdata <= d; l1_mask <= m;
    end
    @(posedge ref_clk);
    l1_wr_en <= 1'b0; l1_rd_en <= 1'b0; ir_wr_en <= 1'b0; ir_rd_en <= 1'b0;
    l1_wdata <= ~l1_wdata; ir_wdata <= ~ir_wdata;
  endtask
endmodule
`default_nettype wire

// file: tb/testbench.sv
// Self-checking bench for the RAM self-test and scan test port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  localparam logic [63:0] D1 = 64'h0123_4567_89ab_cdef;
  localparam logic [63:0] D2 = 64'hfedc_ba98_7654_3210;
  localparam logic [63:0] D3 = 64'h5a5a_c3c3_0f0f_9696;
  localparam logic [63:0] ALL = 64'hffff_ffff_ffff_ffff;
  localparam logic [63:0] LO = 64'h0000_0000_ffff_ffff;
  localparam logic [13:0] A = 14'h2a5c;
  logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, ram_clk_on;
  logic scan_shift_en = 1'b0, ram_hold_during_shift = 1'b0;
  logic ram_clock_force = 1'b0, test_bypass_mode = 1'b0;
  logic [1:0] wait_for_interrupt_state = 2'h0, l1_ack, ir_ack, l1_req, ir_req, l1_cfg, ir_cfg;
  logic [13:0] l1_addr;
  logic [11:0] ir_addr;
  logic [63:0] l1_wdata, l1_rdata, l1_mask, ir_wdata, ir_rdata;
  logic [5:0] l1_sel;
  logic [4:0] ir_sel;
  logic l1_wr_en, l1_rd_en, ir_wr_en, ir_rd_en, ir_bit_wr_en;
  int error_cnt = 0, cmp_count = 0;
  always #25 ref_clk = ~ref_clk;
  rbst_bist_model i_model (.ref_clk(ref_clk), .l1_req(l1_req), .l1_cfg(l1_cfg),
    .l1_addr(l1_addr), .l1_wdata(l1_wdata), .l1_wr_en(l1_wr_en), .l1_rd_en(l1_rd_en),
    .l1_sel(l1_sel), .l1_mask(l1_mask), .ir_req(ir_req), .ir_cfg(ir_cfg), .ir_addr(ir_addr),
    .ir_wdata(ir_wdata), .ir_wr_en(ir_wr_en), .ir_rd_en(ir_rd_en), .ir_sel(ir_sel),
    .ir_bit_wr_en(ir_bit_wr_en));
  rbst_top i_dut (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en),
    .scan_shift_en(scan_shift_en), .ram_hold_during_shift(ram_hold_during_shift),
    .ram_clock_force(ram_clock_force), .test_bypass_mode(test_bypass_mode),
    .wait_for_interrupt_state(wait_for_interrupt_state), .ram_clk_on(ram_clk_on),
    .l1_test_ack(l1_ack), .l1_test_req(l1_req), .l1_test_cfg(l1_cfg),
    .l1_test_addr(l1_addr), .l1_test_wdata(l1_wdata), .l1_test_rdata(l1_rdata),
    .l1_test_wr_en(l1_wr_en), .l1_test_rd_en(l1_rd_en), .l1_test_array_sel(l1_sel),
    .l1_test_bit_mask(l1_mask), .iram_test_ack(ir_ack), .iram_test_req(ir_req),
    .iram_test_cfg(ir_cfg), .iram_test_addr(ir_addr), .iram_test_wdata(ir_wdata),
    .iram_test_rdata(ir_rdata), .iram_test_wr_en(ir_wr_en), .iram_test_rd_en(ir_rd_en),
    .iram_test_array_sel(ir_sel), .iram_test_bit_wr_en(ir_bit_wr_en));
  task automatic report_and_stop();
    $display("Errors %0d, comparisons %0d", error_cnt, cmp_count);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    cmp_count++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input bit p, input logic [5:0] s, input logic [13:0] a,
                    input logic [63:0] d, input logic [63:0] m, input logic c);
    i_model.acc(p, 1'b1, s, a, d, m, c);
  endtask
  // Read data appear in the cycle after the read strobe and hold until the next read
  task automatic rd(input bit p, input logic [5:0] s, input logic [13:0] a,
                    input logic [63:0] exp);
    i_model.acc(p, 1'b0, s, a, 64'h0, 64'h0, 1'b0);
    @(negedge ref_clk);
    chk(p ? ir_rdata : l1_rdata, exp);
  endtask
  task automatic req_chk(input bit p, input logic [1:0] r);
    i_model.set_req(p, r);
    @(posedge ref_clk);
    @(negedge ref_clk);
    chk(p ? ir_ack : l1_ack, {62'h0, ~r});
  endtask
  // Order: scan shift, hold, forced clock, bypass, two wait states
  task automatic pins(input logic [5:0] v);
    @(posedge ref_clk);
    {scan_shift_en, ram_hold_during_shift, ram_clock_force, test_bypass_mode,
     wait_for_interrupt_state} <= v;
    @(negedge ref_clk);
  endtask
  initial begin
    #50000;
    error_cnt++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge ref_clk);
    chk({l1_ack, ir_ack}, 64'hf);
    chk(l1_rdata | ir_rdata, 64'h0);
    rst_n <= 1'b1;
    chk($bits(l1_rdata), 64);
    chk($bits(ir_rdata), 64);
    for (int r = 0; r < 4; r++) begin
      req_chk(1'b0, r[1:0]);
      req_chk(1'b1, r[1:0]);
    end
    wr(0, 6'h0, A, D1, ALL, 0); rd(0, 6'h0, A, D1);
    wr(0, 6'h3, A, D2, ALL, 0); rd(0, 6'h3, A, D2);
    rd(0, 6'h0, A, D1);
    wr(0, 6'h0, A, D2, LO, 0); rd(0, 6'h0, A, (D2 & LO) | (D1 & ~LO));
    rd(0, 6'h4, A, 64'h0);
    pins(6'h30); wr(0, 6'h3, A, D3, ALL, 0); pins(6'h00); rd(0, 6'h3, A, D2);
    pins(6'h03); chk(ram_clk_on, 64'h0);
    wr(0, 6'h3, A, D3, ALL, 0); pins(6'h00); rd(0, 6'h3, A, D2);
    pins(6'h0b); chk(ram_clk_on, 64'h1);
    wr(0, 6'h3, A, D3, ALL, 0); rd(0, 6'h3, A, D3);
    pins(6'h07); chk(ram_clk_on, 64'h1);
    wr(0, 6'h3, A, D1, ALL, 0); rd(0, 6'h3, A, D1);
    pins(6'h00);
    @(posedge ref_clk) clk_en <= 1'b0;
    wr(0, 6'h3, A, D3, ALL, 0); rd(0, 6'h3, A, D1);
    @(posedge ref_clk) clk_en <= 1'b1;
    rd(0, 6'h3, A, D1);
    wr(1, 6'h0, A, D1, ALL, 0); rd(1, 6'h0, A, D1);
    wr(1, 6'h0, A, D2, 64'h0, 0); rd(1, 6'h0, A, D1);
    wr(1, 6'h0, A, D3, ALL, 1); rd(1, 6'h1, A, D3);
    rd(1, 6'h0, A, D3);
    req_chk(1'b0, 2'h0);
    wr(0, 6'h0, A, D3, ALL, 0); req_chk(1'b0, 2'h2);
    rd(0, 6'h0, A, (D2 & LO) | (D1 & ~LO));
    report_and_stop();
  end
endmodule
`default_nettype wire
